// ---- src/icw_pkg.sv ----
// Package with register map, field positions and carriers for the interrupt control word.
package icw_pkg;
  localparam int unsigned ICW_ADDR_W = 4;
  localparam int unsigned ICW_NUM_EXT = 5;
  localparam logic [ICW_ADDR_W-1:0] ICW_OFS_CTRL1 = 4'h0;
  localparam logic [ICW_ADDR_W-1:0] ICW_OFS_EXT_IN = 4'h4;
  localparam logic [ICW_ADDR_W-1:0] ICW_OFS_EXT_REQ = 4'h8;
  localparam int unsigned ICW_BIT_GIE = 15;
  localparam int unsigned ICW_BIT_IRQ_DISABLE_INSTR_ACTIVE = 14;
  localparam int unsigned ICW_BIT_TRAP = 13;
  localparam int unsigned ICW_BIT_ALT = 8;
  localparam int unsigned ICW_BIT_POL_HI = 4;
  localparam logic [15:0] ICW_CTRL1_RESET = 16'h8000;
  localparam logic [31:0] ICW_UNMAPPED_DATA = 32'h0000_0000;

  typedef struct packed {
    logic global_irq_enable;
    logic soft_trap_control;
    logic alt_vector_table_select;
    logic [ICW_NUM_EXT-1:0] ext_edge_polarity;
  } icw_ctrl_t;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ICW_ADDR_W-1:0] adr;
    logic [31:0] dat;
  } icw_wb_req_t;
endpackage

// ---- src/icw_edge_det.sv ----
// Three-stage synchroniser with selectable edge detection for one external input.
module icw_edge_det (
  input wire logic clk_i,   // System clock.
  input wire logic rst_i,   // Synchronous reset, active high.
  input wire logic pin_i,   // Asynchronous external interrupt pin.
  input wire logic neg_i,   // One selects falling edge, zero rising edge.
  output logic level_o,     // Synchronised level.
  output logic edge_o       // One-cycle pulse on the selected edge.
);
  logic [2:0] sync_q;
  logic [2:0] sync_d;
  logic edge_q;
  logic edge_d;

  always_comb begin
    sync_d = {sync_q[1:0], pin_i};
    // A change counts while the second stage holds the new level and the third stage still holds the old one.
    if (neg_i) begin
      edge_d = sync_q[2] & ~sync_q[1];
    end else begin
      edge_d = ~sync_q[2] & sync_q[1];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync_q <= 3'h0;
      edge_q <= 1'b0;
    end else begin
      sync_q <= sync_d;
      edge_q <= edge_d;
    end
  end

  assign level_o = sync_q[2];
  assign edge_o = edge_q;
endmodule

// ---- src/icw_ctrl.sv ----
// Interrupt control word one with edge-detected external interrupt requests.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
module icw_ctrl #(
  parameter int unsigned NUM_EXT = icw_pkg::ICW_NUM_EXT  // External interrupt inputs.
) (
  input wire logic clk_i,                       // System clock, 20 MHz.
  input wire logic rst_i,                       // Synchronous reset, active high.
  input wire logic wb_cyc_i,                    // Wishbone cycle.
  input wire logic wb_stb_i,                    // Wishbone strobe.
  input wire logic wb_we_i,                     // Wishbone write enable.
  input wire logic [3:0] wb_sel_i,              // Wishbone byte selects.
  input wire logic [icw_pkg::ICW_ADDR_W-1:0] wb_adr_i,  // Wishbone byte address.
  input wire logic [31:0] wb_dat_i,             // Wishbone write data.
  output logic [31:0] wb_dat_o,                 // Wishbone read data.
  output logic wb_ack_o,                        // Wishbone acknowledge.
  input wire logic [NUM_EXT-1:0] ext_irq_i,     // External interrupt pins.
  input wire logic irq_disable_instr_active_active_i,               // Interrupt-disable instruction in effect.
  input wire logic ord_irq_i,                   // Ordinary interrupt request from sources.
  input wire logic trap_i,                      // Trap request.
  output logic cpu_irq_o,                       // Request passed to the CPU.
  output logic alt_vector_table_select_o,       // Alternate vector table in use.
  output logic soft_trap_control_o,             // Software trap control bit.
  output logic [NUM_EXT-1:0] ext_irq_req_o      // Sticky external interrupt requests.
);
  icw_pkg::icw_ctrl_t ctrl_q;
  icw_pkg::icw_ctrl_t ctrl_d;
  logic [NUM_EXT-1:0] req_q;
  logic [NUM_EXT-1:0] req_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;
  logic [NUM_EXT-1:0] ext_level;
  logic [NUM_EXT-1:0] ext_edge;
  logic irq_disable_instr_active_q;
  logic access;
  logic wr_lo;
  logic wr_hi;

  function automatic logic [15:0] ctrl_word(input icw_pkg::icw_ctrl_t c, input logic irq_disable_instr_active);
    logic [15:0] w;
    w = 16'h0000;
    w[icw_pkg::ICW_BIT_GIE] = c.global_irq_enable;
    w[icw_pkg::ICW_BIT_IRQ_DISABLE_INSTR_ACTIVE] = irq_disable_instr_active;
    w[icw_pkg::ICW_BIT_TRAP] = c.soft_trap_control;
    w[icw_pkg::ICW_BIT_ALT] = c.alt_vector_table_select;
    w[icw_pkg::ICW_BIT_POL_HI:0] = c.ext_edge_polarity;
    return w;
  endfunction

  for (genvar i = 0; i < NUM_EXT; i++) begin : g_ext
    icw_edge_det u_det (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .pin_i(ext_irq_i[i]),
      .neg_i(ctrl_q.ext_edge_polarity[i]),
      .level_o(ext_level[i]),
      .edge_o(ext_edge[i])
    );
  end

  assign access = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr_lo = access & wb_we_i & wb_sel_i[0];
  assign wr_hi = access & wb_we_i & wb_sel_i[1];

  always_comb begin
    ctrl_d = ctrl_q;
    req_d = req_q;
    ack_d = access;
    rdat_d = rdat_q;
    if (wb_adr_i == icw_pkg::ICW_OFS_CTRL1) begin
      if (wr_hi) begin
        ctrl_d.global_irq_enable = wb_dat_i[icw_pkg::ICW_BIT_GIE];
        ctrl_d.soft_trap_control = wb_dat_i[icw_pkg::ICW_BIT_TRAP];
        ctrl_d.alt_vector_table_select = wb_dat_i[icw_pkg::ICW_BIT_ALT];
      end
      if (wr_lo) begin
        ctrl_d.ext_edge_polarity = wb_dat_i[icw_pkg::ICW_BIT_POL_HI:0];
      end
      rdat_d = {16'h0000, ctrl_word(ctrl_q, irq_disable_instr_active_q)};
    end else if (wb_adr_i == icw_pkg::ICW_OFS_EXT_IN) begin
      rdat_d = 32'(ext_level);
    end else if (wb_adr_i == icw_pkg::ICW_OFS_EXT_REQ) begin
      // Writing a one clears a request; a new edge in the same cycle wins.
      if (wr_lo) begin
        req_d = req_q & ~wb_dat_i[NUM_EXT-1:0];
      end
      rdat_d = 32'(req_q);
    end else begin
      rdat_d = icw_pkg::ICW_UNMAPPED_DATA;
    end
    req_d = req_d | ext_edge;
    if (!access) begin
      rdat_d = rdat_q;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= icw_pkg::icw_ctrl_t'({icw_pkg::ICW_CTRL1_RESET[icw_pkg::ICW_BIT_GIE], 1'b0,
                1'b0, 5'h00});
      req_q <= '0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0000_0000;
      irq_disable_instr_active_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      req_q <= req_d;
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      irq_disable_instr_active_q <= irq_disable_instr_active_active_i;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;
  assign cpu_irq_o = trap_i | (ctrl_q.global_irq_enable & (ord_irq_i | (|req_q)));
  assign alt_vector_table_select_o = ctrl_q.alt_vector_table_select;
  assign soft_trap_control_o = ctrl_q.soft_trap_control;
  assign ext_irq_req_o = req_q;

  gie_reset_a: assert property (@(posedge clk_i) rst_i |=> ctrl_q.global_irq_enable)
    else $error("global enable not one after reset");
  gie_block_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_q.global_irq_enable && !trap_i) |-> !cpu_irq_o)
    else $error("request passed while globally disabled");
  trap_pass_a: assert property (@(posedge clk_i) disable iff (rst_i) trap_i |-> cpu_irq_o)
    else $error("trap blocked");
  irq_disable_instr_active_read_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_we_i && wb_adr_i == icw_pkg::ICW_OFS_CTRL1)
    |=> wb_dat_o[icw_pkg::ICW_BIT_IRQ_DISABLE_INSTR_ACTIVE] == $past(irq_disable_instr_active_q))
    else $error("status bit 14 mismatch");
  alt_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_hi && wb_adr_i == icw_pkg::ICW_OFS_CTRL1)
    |=> alt_vector_table_select_o == $past(wb_dat_i[icw_pkg::ICW_BIT_ALT]))
    else $error("alternate table select not written");
  pol_write_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (wr_lo && wb_adr_i == icw_pkg::ICW_OFS_CTRL1)
    |=> ctrl_q.ext_edge_polarity == $past(wb_dat_i[icw_pkg::ICW_BIT_POL_HI:0]))
    else $error("polarity bits not written");
  fall_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (ctrl_q.ext_edge_polarity[0] && $fell(ext_level[0]) && $stable(ctrl_q.ext_edge_polarity[0]))
    |=> ##1 req_q[0])
    else $error("falling edge did not set request");
  rise_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (!ctrl_q.ext_edge_polarity[0] && $rose(ext_level[0]) && $stable(ctrl_q.ext_edge_polarity[0]))
    |=> ##1 req_q[0])
    else $error("rising edge did not set request");
  ack_drop_a: assert property (@(posedge clk_i) disable iff (rst_i) wb_ack_o |=> !wb_ack_o)
    else $error("ack held two cycles");

  // Every accepted cycle is answered on the very next edge, so a master that
  // waits for ack can never stall here.
  ack_follow_a: assert property (@(posedge clk_i) disable iff (rst_i)
    access |=> wb_ack_o)
    else $error("accepted cycle not acknowledged");

  // Addresses outside the map must read back as the idle pattern.
  unmapped_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (access && !wb_we_i && wb_adr_i != icw_pkg::ICW_OFS_CTRL1
      && wb_adr_i != icw_pkg::ICW_OFS_EXT_IN && wb_adr_i != icw_pkg::ICW_OFS_EXT_REQ)
    |=> wb_dat_o == icw_pkg::ICW_UNMAPPED_DATA)
    else $error("unmapped address returned data");

  // A detected edge must always land in the sticky request, even when software
  // clears the same bit in that cycle; otherwise an interrupt would be lost.
  edge_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    (|ext_edge) |=> ((req_q & $past(ext_edge)) == $past(ext_edge)))
    else $error("edge pulse did not set its request");

  // Requests are sticky: only a write to the request word may drop them.
  req_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_lo && wb_adr_i == icw_pkg::ICW_OFS_EXT_REQ)
    |=> ((req_q & $past(req_q)) == $past(req_q)))
    else $error("request dropped without a clear");

  // The checks below cover every external input, not only the first one.
  // The request follows the synchronised level by one edge; a pulse with no
  // level change would mean the detector reacts to noise on one stage only.
  for (genvar k = 0; k < NUM_EXT; k++) begin : g_edge_chk
    fall_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (ctrl_q.ext_edge_polarity[k] && $fell(ext_level[k])
        && $stable(ctrl_q.ext_edge_polarity[k]))
      |=> req_q[k])
      else $error("falling edge missed on an input");
    rise_any_a: assert property (@(posedge clk_i) disable iff (rst_i)
      (!ctrl_q.ext_edge_polarity[k] && $rose(ext_level[k])
        && $stable(ctrl_q.ext_edge_polarity[k]))
      |=> req_q[k])
      else $error("rising edge missed on an input");
    quiet_in_a: assert property (@(posedge clk_i) disable iff (rst_i)
      $stable(ext_level[k]) |-> !ext_edge[k])
      else $error("edge pulse without a level change");
  end

  read_c: cover property (@(posedge clk_i) access && !wb_we_i);
  write_c: cover property (@(posedge clk_i) wr_hi && wr_lo);
  edge_c: cover property (@(posedge clk_i) |ext_edge);
  irq_c: cover property (@(posedge clk_i) cpu_irq_o && !trap_i);
  irq_disable_instr_active_c: cover property (@(posedge clk_i) irq_disable_instr_active_q && access && !wb_we_i);
endmodule

// ---- bench/interrupt_control_word_one_tb_top.sv ----
// Self-checking bench for the interrupt control word over classic Wishbone.
module interrupt_control_word_one_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wd = 32'h0;
  logic [31:0] rd;
  logic [31:0] q;
  logic ack;
  logic [4:0] pins = 5'h00;
  logic irq_disable_instr_active = 1'b0;
  logic ord = 1'b0;
  logic trap = 1'b0;
  logic irq;
  logic alt;
  logic strap;
  logic [4:0] req;
  int failures = 0;
  int n_checks = 0;

  always #25 clk_i = ~clk_i;

  icw_ctrl uut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wd), .wb_dat_o(rd), .wb_ack_o(ack),
    .ext_irq_i(pins), .irq_disable_instr_active_active_i(irq_disable_instr_active), .ord_irq_i(ord), .trap_i(trap),
    .cpu_irq_o(irq), .alt_vector_table_select_o(alt), .soft_trap_control_o(strap),
    .ext_irq_req_o(req)
  );

  task automatic conclude;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One classic cycle; the request is held until ack is sampled high or 20 cycles pass.
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) failures++;
  endtask

  task automatic wait_req(input logic [4:0] e);
    int n;
    n = 0;
    while (req !== e && n < 12) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  initial begin
    repeat (2000) @(posedge clk_i);
    failures++;
    conclude();
  end

  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, 4'h0, 32'h0);
    chk("ctrl reset", q, 32'h0000_8000);
    xfer(1'b1, 4'h0, 32'hffff_ffff);
    xfer(1'b0, 4'h0, 32'h0);
    chk("ctrl ones", q, 32'h0000_a11f);
    chk("alt out", {31'h0, alt}, 32'h1);
    chk("trap bit out", {31'h0, strap}, 32'h1);
    irq_disable_instr_active <= 1'b1;
    xfer(1'b0, 4'h0, 32'h0);
    chk("irq_disable_instr_active bit", q, 32'h0000_e11f);
    irq_disable_instr_active <= 1'b0;
    $display("register test done");
    xfer(1'b1, 4'h0, 32'h0000_800a);
    chk("alt off", {31'h0, alt}, 32'h0);
    chk("trap bit off", {31'h0, strap}, 32'h0);
    pins <= 5'h1f;
    wait_req(5'h15);
    chk("rise req", {27'h0, req}, 32'h15);
    xfer(1'b0, 4'h4, 32'h0);
    chk("pin level", q, 32'h1f);
    xfer(1'b0, 4'h8, 32'h0);
    chk("req reg", q, 32'h15);
    xfer(1'b1, 4'h8, 32'h1f);
    pins <= 5'h00;
    wait_req(5'h0a);
    chk("fall req", {27'h0, req}, 32'h0a);
    xfer(1'b1, 4'h8, 32'h1f);
    $display("edge test done");
    xfer(1'b1, 4'h0, 32'h0);
    ord <= 1'b1;
    @(negedge clk_i);
    chk("gated irq", {31'h0, irq}, 32'h0);
    @(posedge clk_i);
    trap <= 1'b1;
    @(negedge clk_i);
    chk("trap pass", {31'h0, irq}, 32'h1);
    xfer(1'b1, 4'h0, 32'h0000_8000);
    trap <= 1'b0;
    @(negedge clk_i);
    chk("open irq", {31'h0, irq}, 32'h1);
    xfer(1'b1, 4'hc, 32'hffff_ffff);
    xfer(1'b0, 4'hc, 32'h0);
    chk("unmapped", q, 32'h0);
    xfer(1'b0, 4'h0, 32'h0);
    chk("ctrl kept", q, 32'h0000_8000);
    $display("gating test done");
    conclude();
  end
endmodule
